// *** common/crsr_pkg.sv ***
// Package of constants for the colour result and status readout block
package crsr_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_SENSOR_STATUS = 8'h13;
	localparam logic [7:0] ADDR_CLEAR_RESULT_LOW = 8'h14;
	localparam logic [7:0] ADDR_CLEAR_RESULT_HIGH = 8'h15;
	localparam logic [7:0] ADDR_RED_RESULT_LOW = 8'h16;
	localparam logic [7:0] ADDR_RED_RESULT_HIGH = 8'h17;
	localparam logic [7:0] ADDR_GREEN_RESULT_LOW = 8'h18;
	localparam logic [7:0] ADDR_GREEN_RESULT_HIGH = 8'h19;
	localparam logic [7:0] ADDR_BLUE_RESULT_LOW = 8'h1a;
	localparam logic [7:0] ADDR_BLUE_RESULT_HIGH = 8'h1b;
	// ----------------------------------------
	// Status fields and reset values
	// ----------------------------------------
	localparam int STATUS_IRQ_BIT = 4;
	localparam int STATUS_DONE_BIT = 0;
	localparam logic [7:0] RESET_STATUS = 8'h00;
	localparam logic [15:0] RESET_RESULT = 16'h0000;
	localparam logic [7:0] RESET_SHADOW = 8'h00;
	localparam logic [7:0] RESET_READ_DATA = 8'h00;
	localparam int NUM_CHANNELS = 4;
endpackage

// *** src/crsr_readout.sv ***
// Status register and shadowed channel result registers of the colour sensor
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Status at 0x13 is read only; writes never change it.
// - Status bit 4 shows the clear-channel threshold interrupt condition.
// - Status bit 0 sets when all four channels finish an integration cycle.
// - Clear, red, green and blue results are each held as 16 unsigned bits.
// - Results map low then high byte: clear, red, green, blue from 0x14 to 0x1b.
// - Reading a low byte copies that channel's upper byte into a shadow register.
// - High byte read after low byte stays consistent despite newer integrations.
// - Interrupt condition raises when clear result is below low or above high threshold.
module crsr_readout #(
	parameter int RESULT_WIDTH = 16
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// Register access from the serial interface, same clock domain
	input wire logic i_reg_read,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Integration engine side
	input wire logic i_integration_end,
	input wire logic [RESULT_WIDTH-1:0] i_clear_value,
	input wire logic [RESULT_WIDTH-1:0] i_red_value,
	input wire logic [RESULT_WIDTH-1:0] i_green_value,
	input wire logic [RESULT_WIDTH-1:0] i_blue_value,
	input wire logic [RESULT_WIDTH-1:0] i_low_threshold,
	input wire logic [RESULT_WIDTH-1:0] i_high_threshold,
	input wire logic i_irq_flag_clear,
	input wire logic i_done_flag_clear,
	output logic o_clear_threshold_irq_flag,
	output logic o_integration_done_flag
);

	// ----------------------------------------
	// Result storage
	// ----------------------------------------
	logic [RESULT_WIDTH-1:0] result_reg [crsr_pkg::NUM_CHANNELS];
	logic [7:0] shadow_reg;
	logic irq_flag_reg;
	logic done_flag_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic out_of_range;
	logic addr_is_result;
	logic [1:0] chan_index;
	logic [7:0] rdata_next;
	logic [7:0] status_view;

	// Channel index from result address, both bytes of a pair share it
	function automatic logic [1:0] crsr_channel(input logic [7:0] addr);
		logic [7:0] delta;
		delta = addr - crsr_pkg::ADDR_CLEAR_RESULT_LOW;
		return delta[2:1];
	endfunction

	assign addr_is_result = (i_reg_addr >= crsr_pkg::ADDR_CLEAR_RESULT_LOW) &&
		(i_reg_addr <= crsr_pkg::ADDR_BLUE_RESULT_HIGH);
	assign chan_index = crsr_channel(i_reg_addr);

	// Whole channel set is captured together so the four values come from one cycle
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			for (int k = 0; k < crsr_pkg::NUM_CHANNELS; k++) begin
				result_reg[k] <= crsr_pkg::RESET_RESULT[RESULT_WIDTH-1:0];
			end
		end else if (i_integration_end) begin
			result_reg[0] <= i_clear_value;
			result_reg[1] <= i_red_value;
			result_reg[2] <= i_green_value;
			result_reg[3] <= i_blue_value;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	assign out_of_range = (i_clear_value < i_low_threshold) || (i_clear_value > i_high_threshold);

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			irq_flag_reg <= crsr_pkg::RESET_STATUS[crsr_pkg::STATUS_IRQ_BIT];
		end else if (i_integration_end && out_of_range) begin
			irq_flag_reg <= 1'b1;
		end else if (i_irq_flag_clear) begin
			irq_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			done_flag_reg <= crsr_pkg::RESET_STATUS[crsr_pkg::STATUS_DONE_BIT];
		end else if (i_integration_end) begin
			done_flag_reg <= 1'b1;
		end else if (i_done_flag_clear) begin
			done_flag_reg <= 1'b0;
		end
	end

	always_comb begin
		status_view = 8'h00;
		status_view[crsr_pkg::STATUS_IRQ_BIT] = irq_flag_reg;
		status_view[crsr_pkg::STATUS_DONE_BIT] = done_flag_reg;
	end

	// ----------------------------------------
	// Shadow of the upper byte
	// ----------------------------------------
	// A later integration updates result_reg but not the shadow, so a pair stays coherent
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			shadow_reg <= crsr_pkg::RESET_SHADOW;
		end else if (i_reg_read && addr_is_result && !i_reg_addr[0]) begin
			shadow_reg <= result_reg[chan_index][RESULT_WIDTH-1 -: 8];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Writes are not decoded at all: status and results have no write path
	always_comb begin
		rdata_next = 8'h00;
		if (i_reg_addr == crsr_pkg::ADDR_SENSOR_STATUS) begin
			rdata_next = status_view;
		end else if (addr_is_result && !i_reg_addr[0]) begin
			rdata_next = result_reg[chan_index][7:0];
		end else if (addr_is_result) begin
			rdata_next = shadow_reg;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rdata_reg <= crsr_pkg::RESET_READ_DATA;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= i_reg_read;
			if (i_reg_read) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_reg_rvalid = rvalid_reg;
	assign o_clear_threshold_irq_flag = irq_flag_reg;
	assign o_integration_done_flag = done_flag_reg;

	// i_reg_write and i_reg_wdata are accepted and discarded
	logic unused_write;
	assign unused_write = i_reg_write ^ (^i_reg_wdata);

endmodule

`default_nettype wire

// *** testbench/crsr_checker_sva.sv ***
// Port checker for the colour result readout block
`timescale 1ns/1ps
`default_nettype none
module crsr_checker #(parameter int RESULT_WIDTH = 16) (
	input wire logic i_clock, i_sys_rst, i_reg_read, i_integration_end,
	input wire logic [7:0] i_reg_addr, o_reg_rdata,
	input wire logic o_reg_rvalid, i_irq_flag_clear, i_done_flag_clear,
	input wire logic [RESULT_WIDTH-1:0] i_clear_value, i_low_threshold, i_high_threshold,
	input wire logic o_clear_threshold_irq_flag, o_integration_done_flag);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	a_read_answer: assert property (i_reg_read |=> o_reg_rvalid) else $error("no read answer");
	a_read_idle: assert property (!i_reg_read |=> !o_reg_rvalid && $stable(o_reg_rdata)) else $error("stray read data");
	a_status_read: assert property (i_reg_read && i_reg_addr == 8'h13 |=> o_reg_rdata ==
		{3'h0, $past(o_clear_threshold_irq_flag), 3'h0, $past(o_integration_done_flag)}) else $error("bad status");
	a_unmapped_zero: assert property (i_reg_read && (i_reg_addr < 8'h13 || i_reg_addr > 8'h1b)
		|=> o_reg_rdata == 8'h00) else $error("unmapped not zero");
	a_done_set: assert property (i_integration_end |=> o_integration_done_flag) else $error("done not set");
	a_done_clear: assert property (i_done_flag_clear && !i_integration_end |=> !o_integration_done_flag)
		else $error("done not cleared");
	a_irq_set: assert property (i_integration_end && (i_clear_value < i_low_threshold ||
		i_clear_value > i_high_threshold) |=> o_clear_threshold_irq_flag) else $error("irq not set");
	a_irq_keep: assert property (!i_integration_end && !i_irq_flag_clear
		|=> $stable(o_clear_threshold_irq_flag)) else $error("irq moved");
	c_status: cover property (i_reg_read && i_reg_addr == 8'h13);
	c_low: cover property (i_reg_read && i_reg_addr == 8'h14);
	c_irq: cover property ($rose(o_clear_threshold_irq_flag));
endmodule
bind crsr_readout crsr_checker #(.RESULT_WIDTH(RESULT_WIDTH)) chk (.*);
`default_nettype wire

// *** testbench/crsr_host_model.sv ***
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module crsr_host_model (
	input wire logic i_clock,
	input wire logic [7:0] i_rdata,
	output logic o_read, o_write,
	output logic [7:0] o_addr, o_wdata);
	initial {o_read, o_write, o_addr, o_wdata} = '0;
	task rd1(input logic [7:0] a, output logic [7:0] q);
		@(posedge i_clock) {o_read, o_addr} <= {1'b1, a};
		@(posedge i_clock) {o_read, o_addr} <= {1'b0, ~a};
		#1 q = i_rdata;
	endtask
	task word(input logic [7:0] a, output logic [15:0] q);
		rd1(a, q[7:0]);
		rd1(a + 8'h1, q[15:8]);
	endtask
	task wr1(input logic [7:0] a);
		@(posedge i_clock) {o_write, o_addr, o_wdata} <= {1'b1, a, 8'hff};
		@(posedge i_clock) {o_write, o_addr, o_wdata} <= {1'b0, ~a, 8'h00};
	endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 0, rst = 1, ie = 0, ic = 0, dc = 0, rd, wr, rv, irqf, donef;
	logic [7:0] ad, wd, rdat, d;
	logic [15:0] c = 0, r = 0, g = 0, b = 0, w;
	int err_count = 0, num_checks = 0, cyc = 0;
	logic [23:0] rows [4] = '{24'h141234, 24'h16edcb, 24'h1812cb, 24'h1a1235};
	logic [19:0] thr [3] = '{20'h00501, 20'hf0011, 20'h01000};
	crsr_readout #(.RESULT_WIDTH(16)) uut (.i_clock(clk), .i_sys_rst(rst), .i_reg_read(rd), .i_reg_write(wr),
		.i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_integration_end(ie),
		.i_clear_value(c), .i_red_value(r), .i_green_value(g), .i_blue_value(b), .i_low_threshold(16'h0100),
		.i_high_threshold(16'hf000), .i_irq_flag_clear(ic), .i_done_flag_clear(dc),
		.o_clear_threshold_irq_flag(irqf), .o_integration_done_flag(donef));
	crsr_host_model h (.i_clock(clk), .i_rdata(rdat), .o_read(rd), .o_write(wr), .o_addr(ad), .o_wdata(wd));
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	task chk(input logic [15:0] e, input logic [15:0] s, input string n);
		num_checks++;
		if (s !== e) begin
			$display("[ERR] %s exp %h got %h", n, e, s);
			err_count++;
		end
	endtask
	task integ(input logic [15:0] v);
		@(posedge clk) {ie, c, r, g, b} <= {1'b1, v, ~v, v ^ 16'h00ff, v + 16'h1};
		@(posedge clk) ie <= 0;
	endtask
	task clr();
		@(posedge clk) {ic, dc} <= 2'b11;
		@(posedge clk) {ic, dc} <= 2'b00;
	endtask
	task complete_run();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		integ(16'h1234);
		foreach (rows[i]) begin
			h.word(rows[i][23:16], w);
			chk(rows[i][15:0], w, "word");
		end
		h.wr1(8'h13);
		h.wr1(8'h14);
		h.rd1(8'h13, d);
		chk(16'h0001, {8'h0, d}, "status");
		chk(16'h0001, {15'h0, rv}, "rvalid");
		h.word(8'h14, w);
		chk(16'h1234, w, "word");
		h.rd1(8'h1c, d);
		chk(16'h0000, {8'h0, d}, "unmapped");
		h.rd1(8'h14, d);
		integ(16'h5678);
		h.rd1(8'h15, d);
		chk(16'h0012, {8'h0, d}, "shadow");
		foreach (thr[i]) begin
			clr();
			integ(thr[i][19:4]);
			h.rd1(8'h13, d);
			chk({11'h0, thr[i][0], 4'h1}, {8'h0, d}, "irq status");
			chk({15'h0, thr[i][0]}, {15'h0, irqf}, "irq flag");
		end
		clr();
		h.rd1(8'h13, d);
		chk(16'h0000, {8'h0, d}, "cleared");
		chk(16'h0000, {14'h0, irqf, donef}, "flags");
		integ(16'h0010);
		@(posedge clk) rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		h.rd1(8'h13, d);
		chk(16'h0000, {8'h0, d}, "reset status");
		chk(16'h0000, {14'h0, irqf, donef}, "reset flags");
		h.rd1(8'h15, d);
		chk(16'h0000, {8'h0, d}, "reset shadow");
		h.word(8'h14, w);
		chk(16'h0000, w, "reset word");
		complete_run();
	end
endmodule
`default_nettype wire
